// ===== src/dsc_top.sv
// Power state machine of the stepper drive with its holding registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: Enable operation leaves quick stop, current kept
// RL2: Master waits settling time before new setpoints
// RL3: Command bits 7,3,2,1,0 carry state commands
// RL4: Decode commands by bit patterns; bit7 edge resets
// RL5: Status bits 6,5,3,2,1,0 encode state
// RL6: Command 0x0006 gives ready to switch on
// RL7: Command 0x0007 switches on only with supply
// RL8: Command 0x000F gives operation enabled
// RL9: Bit4 starts motion; bit6 relative if mode allows
// RL10: Direct step 0x0006 to 0x000F allowed
// RL11: Winding current on only when operation enabled
// RL12: Mode register selects position, velocity, homing
// RL13: 32-bit values use two consecutive word registers
// RL14: Switch on needs supply present 500 ms
// RL15: Reset enters switch on disabled
// RL16: 32-bit value committed on second half write; code commits on the low word write, whichever half comes second
// RL17: Unmatched command leaves state unchanged
module dsc_top #(
   parameter int HV_QUAL_CYC = dsc_pkg::HV_QUAL_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic hv_present_i,
   input wire logic fault_i,
   input wire logic motion_done_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_err_o,
   output logic current_on_o,
   output logic motion_start_o,
   output logic motion_rel_o,
   output logic [15:0] mode_o,
   output logic [31:0] target_pos_o
);
   // Pattern match on the low command nibble
   function automatic logic cmd_is(input logic [15:0] word,
                                   input logic [3:0] m,
                                   input logic [3:0] v);
      cmd_is = !word[dsc_pkg::CB_FRST] && ((word[3:0] & m) == v);
   endfunction

   dsc_pkg::dsc_state_t state_r; // Power state
   dsc_pkg::dsc_state_t state_nxt;
   logic [15:0] cmd_r; // Last command word
   logic [15:0] tpos_hi_r; // Staged upper half
   logic [15:0] rdata_nxt;
   logic hv_ok; // Supply qualified
   logic moving_r; // Motion in progress
   logic spack_r; // Setpoint acknowledge

   // Supply qualification timer
   dsc_hv_qualify #(
      .QUAL_CYC(HV_QUAL_CYC)
   ) u_hv (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .hv_present_i(hv_present_i),
      .hv_qualified_o(hv_ok)
   );

   // Address decode
   wire wr_cmd = reg_wr_i && (reg_addr_i == dsc_pkg::ADDR_CMD);
   wire wr_mode = reg_wr_i && (reg_addr_i == dsc_pkg::ADDR_MODE);
   wire wr_lo = reg_wr_i && (reg_addr_i == dsc_pkg::ADDR_TPOS_LO);
   wire wr_hi = reg_wr_i && (reg_addr_i == dsc_pkg::ADDR_TPOS_HI);
   wire [15:0] cmd_wd = reg_wdata_i;

   // Command decode on a command write
   wire c_shut = wr_cmd &&
                 cmd_is(cmd_wd, dsc_pkg::M_SHUT, dsc_pkg::V_SHUT); // RL4
   wire c_swon = wr_cmd &&
                 cmd_is(cmd_wd, dsc_pkg::M_SWON, dsc_pkg::V_SWON); // RL4
   wire c_disv = wr_cmd &&
                 cmd_is(cmd_wd, dsc_pkg::M_DISV, dsc_pkg::V_DISV); // RL4
   wire c_qstp = wr_cmd &&
                 cmd_is(cmd_wd, dsc_pkg::M_QSTP, dsc_pkg::V_QSTP); // RL4
   wire c_disop = wr_cmd &&
                  cmd_is(cmd_wd, dsc_pkg::M_OPS, dsc_pkg::V_DISOP); // RL4
   wire c_enop = wr_cmd &&
                 cmd_is(cmd_wd, dsc_pkg::M_OPS, dsc_pkg::V_ENOP); // RL4
   // Fault reset on a low to high step of bit 7
   wire c_frst = wr_cmd && cmd_wd[dsc_pkg::CB_FRST] &&
                 !cmd_r[dsc_pkg::CB_FRST]; // RL4
   // Return from quick stop allowed by stop option
   wire qs_return = (dsc_pkg::QSTOP_OPTION == 5); // RL1

   // Enable operation pattern, also gates the motion start
   wire c_enop_hold = cmd_is(cmd_wd, dsc_pkg::M_OPS, dsc_pkg::V_ENOP);
   // Motion start on a rising new setpoint bit
   wire c_start = wr_cmd && (state_r == dsc_pkg::ST_OPEN) && c_enop_hold &&
                  cmd_wd[dsc_pkg::CB_NEWSP] && !cmd_r[dsc_pkg::CB_NEWSP]; // RL9
   // Relative only in profile position mode
   wire rel_ok = (mode_o == dsc_pkg::MODE_PPOS) &&
                 cmd_wd[dsc_pkg::CB_REL]; // RL9

   // Next state
   always_comb
   begin
      state_nxt = state_r; // RL17
      case (state_r)
         dsc_pkg::ST_SOD:
         begin
            if (c_shut)
               state_nxt = dsc_pkg::ST_RTSO; // RL6
         end
         dsc_pkg::ST_RTSO:
         begin
            if (c_disv || c_qstp)
               state_nxt = dsc_pkg::ST_SOD;
            else if (c_enop && hv_ok)
               state_nxt = dsc_pkg::ST_OPEN; // RL10
            else if (c_swon && hv_ok)
               state_nxt = dsc_pkg::ST_SWON; // RL7 RL14
         end
         dsc_pkg::ST_SWON:
         begin
            if (c_disv || c_qstp)
               state_nxt = dsc_pkg::ST_SOD;
            else if (c_shut)
               state_nxt = dsc_pkg::ST_RTSO;
            else if (c_enop)
               state_nxt = dsc_pkg::ST_OPEN; // RL8
         end
         dsc_pkg::ST_OPEN:
         begin
            if (c_disv)
               state_nxt = dsc_pkg::ST_SOD;
            else if (c_qstp)
               state_nxt = dsc_pkg::ST_QSA;
            else if (c_shut)
               state_nxt = dsc_pkg::ST_RTSO;
            else if (c_disop)
               state_nxt = dsc_pkg::ST_SWON;
         end
         dsc_pkg::ST_QSA:
         begin
            if (c_disv)
               state_nxt = dsc_pkg::ST_SOD;
            else if (c_enop && qs_return)
               state_nxt = dsc_pkg::ST_OPEN; // RL1
         end
         dsc_pkg::ST_FAULT:
         begin
            if (c_frst && !fault_i)
               state_nxt = dsc_pkg::ST_SOD;
         end
         default:
            state_nxt = dsc_pkg::ST_SOD;
      endcase
      // Internal fault overrides every state
      if (fault_i)
         state_nxt = dsc_pkg::ST_FAULT;
   end

   // Status word assembly
   wire st_sod = (state_r == dsc_pkg::ST_SOD);
   wire st_rtso = (state_r == dsc_pkg::ST_RTSO);
   wire st_swon = (state_r == dsc_pkg::ST_SWON);
   wire st_open = (state_r == dsc_pkg::ST_OPEN);
   wire st_qsa = (state_r == dsc_pkg::ST_QSA);
   wire st_flt = (state_r == dsc_pkg::ST_FAULT);
   logic [15:0] stat;
   always_comb
   begin
      stat = 16'h0000;
      stat[dsc_pkg::SB_RTSO] = st_rtso | st_swon | st_open | st_qsa; // RL5
      stat[dsc_pkg::SB_SWON] = st_swon | st_open | st_qsa; // RL5
      stat[dsc_pkg::SB_OPEN] = st_open | st_qsa; // RL5
      stat[dsc_pkg::SB_FAULT] = st_flt; // RL5
      stat[dsc_pkg::SB_QSTOP] = st_sod | st_rtso | st_swon | st_open; // RL5
      stat[dsc_pkg::SB_SOD] = st_sod; // RL5
      stat[dsc_pkg::SB_VOLT] = hv_present_i; // RL6
      stat[dsc_pkg::SB_REMOTE] = 1'b1;
      stat[dsc_pkg::SB_TREACH] = (st_open | st_qsa) && !moving_r; // RL8
      stat[dsc_pkg::SB_SPACK] = spack_r; // RL8
   end

   // Read data select
   assign rdata_nxt = (reg_addr_i == dsc_pkg::ADDR_CMD) ? cmd_r :
                      (reg_addr_i == dsc_pkg::ADDR_STAT) ? stat :
                      (reg_addr_i == dsc_pkg::ADDR_MODE) ? mode_o :
                      (reg_addr_i == dsc_pkg::ADDR_TPOS_LO) ?
                         target_pos_o[15:0] :
                      (reg_addr_i == dsc_pkg::ADDR_TPOS_HI) ?
                         target_pos_o[31:16] : 16'h0000;
   wire mapped = (reg_addr_i == dsc_pkg::ADDR_CMD) ||
                 (reg_addr_i == dsc_pkg::ADDR_STAT) ||
                 (reg_addr_i == dsc_pkg::ADDR_MODE) ||
                 (reg_addr_i == dsc_pkg::ADDR_TPOS_LO) ||
                 (reg_addr_i == dsc_pkg::ADDR_TPOS_HI);

   // State, current gate and command register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= dsc_pkg::ST_SOD; // RL15
         cmd_r <= dsc_pkg::CMD_RST;
         current_on_o <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (wr_cmd)
            cmd_r <= cmd_wd; // RL3
         // Current held in enabled and quick stop states
         current_on_o <= (state_nxt == dsc_pkg::ST_OPEN) ||
                         (state_nxt == dsc_pkg::ST_QSA); // RL11 RL1
      end
   end

   // Mode and 32-bit target position registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_o <= dsc_pkg::MODE_RST;
         tpos_hi_r <= dsc_pkg::TPOS_RST[31:16];
         target_pos_o <= dsc_pkg::TPOS_RST;
      end
      else
      begin
         if (wr_mode)
            mode_o <= reg_wdata_i; // RL12
         if (wr_hi)
            tpos_hi_r <= reg_wdata_i; // RL13
         // Commit both halves on the low word write
         if (wr_lo)
            target_pos_o <= {tpos_hi_r, reg_wdata_i}; // RL16
      end
   end

   // Motion start pulse and tracking
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         motion_start_o <= 1'b0;
         motion_rel_o <= 1'b0;
         moving_r <= 1'b0;
         spack_r <= 1'b0;
      end
      else
      begin
         motion_start_o <= c_start; // RL9
         if (c_start)
            motion_rel_o <= rel_ok; // RL9
         // Start wins over a done in the same cycle
         if (c_start)
            moving_r <= 1'b1;
         else if (motion_done_i || !st_open)
            moving_r <= 1'b0;
         if (wr_cmd)
            spack_r <= cmd_wd[dsc_pkg::CB_NEWSP] && st_open;
      end
   end

   // Register read answer
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= 16'h0000;
         reg_rvalid_o <= 1'b0;
         reg_err_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         reg_rdata_o <= reg_rd_i ? rdata_nxt : 16'h0000;
         reg_err_o <= (reg_rd_i || reg_wr_i) && !mapped;
      end
   end
endmodule
`default_nettype wire

// ===== src/dsc_pkg.sv
// Shared constants of the drive state control block
package dsc_pkg;
   // Holding register word addresses
   localparam logic [15:0] ADDR_CMD = 16'h03E8;
   localparam logic [15:0] ADDR_STAT = 16'h03E9;
   localparam logic [15:0] ADDR_MODE = 16'h0411;
   localparam logic [15:0] ADDR_TPOS_LO = 16'h03F0;
   localparam logic [15:0] ADDR_TPOS_HI = 16'h03F1;
   // Reset values
   localparam logic [15:0] CMD_RST = 16'h0000;
   localparam logic [15:0] MODE_RST = 16'h0001;
   localparam logic [31:0] TPOS_RST = 32'h0000_0000;
   // Mode values
   localparam logic [15:0] MODE_PPOS = 16'h0001;
   localparam logic [15:0] MODE_PVEL = 16'h0003;
   localparam logic [15:0] MODE_HOME = 16'h0006;
   // Command word bit positions
   localparam int CB_SWON = 0;
   localparam int CB_ENV = 1;
   localparam int CB_QSTOP = 2;
   localparam int CB_ENOP = 3;
   localparam int CB_NEWSP = 4;
   localparam int CB_REL = 6;
   localparam int CB_FRST = 7;
   // Command patterns over bits 3..0: mask and value
   localparam logic [3:0] M_SHUT = 4'h7;
   localparam logic [3:0] V_SHUT = 4'h6;
   localparam logic [3:0] M_SWON = 4'h7;
   localparam logic [3:0] V_SWON = 4'h7;
   localparam logic [3:0] M_DISV = 4'h2;
   localparam logic [3:0] V_DISV = 4'h0;
   localparam logic [3:0] M_QSTP = 4'h6;
   localparam logic [3:0] V_QSTP = 4'h2;
   localparam logic [3:0] M_OPS = 4'hF;
   localparam logic [3:0] V_DISOP = 4'h7;
   localparam logic [3:0] V_ENOP = 4'hF;
   // Status word bit positions
   localparam int SB_RTSO = 0;
   localparam int SB_SWON = 1;
   localparam int SB_OPEN = 2;
   localparam int SB_FAULT = 3;
   localparam int SB_VOLT = 4;
   localparam int SB_QSTOP = 5;
   localparam int SB_SOD = 6;
   localparam int SB_REMOTE = 9;
   localparam int SB_TREACH = 10;
   localparam int SB_SPACK = 12;
   // High voltage qualification time
   localparam int HV_QUAL_MS = 500;
   localparam int CLK_HZ = 50_000_000;
   localparam int HV_QUAL_CYC = HV_QUAL_MS * (CLK_HZ / 1000);
   // Stop behaviour option that allows return from quick stop
   localparam int QSTOP_OPTION = 5;
   // Power states, one-hot
   typedef enum logic [5:0] {
      ST_SOD = 6'b00_0001,
      ST_RTSO = 6'b00_0010,
      ST_SWON = 6'b00_0100,
      ST_OPEN = 6'b00_1000,
      ST_QSA = 6'b01_0000,
      ST_FAULT = 6'b10_0000
   } dsc_state_t;
endpackage

// ===== src/dsc_hv_qualify.sv
// Qualification timer for the high voltage supply presence
`timescale 1ns/1ps
`default_nettype none
module dsc_hv_qualify #(
   parameter int QUAL_CYC = dsc_pkg::HV_QUAL_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hv_present_i,
   output logic hv_qualified_o
);
   // Counter wide enough for the qualification count
   localparam int CNT_W = $clog2(QUAL_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(QUAL_CYC - 1);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic qual_nxt;

   // Count while supply is present, restart on any drop
   assign cnt_nxt = !hv_present_i ? '0 :
                    (cnt_r == CNT_MAX) ? cnt_r : cnt_r + CNT_W'(1);
   assign qual_nxt = hv_present_i && (cnt_r == CNT_MAX);

   // Counter and qualified flag
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_r <= '0;
         hv_qualified_o <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         hv_qualified_o <= qual_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== tb/dsc_checker.sv
// Assertion checker for the drive state control ports
`timescale 1ns/1ps
`default_nettype none
module dsc_checker (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic fault_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic reg_err_o,
   input wire logic current_on_o,
   input wire logic motion_start_o,
   input wire logic [15:0] mode_o
);
   // Single domain; reset disables every check
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Address hits on command write and status read
   wire logic cmd_wr = reg_wr_i && reg_addr_i == dsc_pkg::ADDR_CMD;
   wire logic stat_rd = reg_rd_i && reg_addr_i == dsc_pkg::ADDR_STAT;
   // Start command written while current is on
   wire logic start_cmd = cmd_wr && reg_wdata_i[4:0] == 5'h1F && current_on_o;
   a_stat_answer: assert property (stat_rd
      |=> reg_rvalid_o && !reg_err_o)
      else $error("status read not answered");
   a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read data without read");
   a_idle_rdata: assert property (!reg_rvalid_o
      |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero when idle");
   a_sod_code: assert property (reg_rvalid_o && $past(stat_rd)
      && reg_rdata_o[6]
      |-> reg_rdata_o[5] && reg_rdata_o[3:0] == 4'h0)
      else $error("bad disabled state code");
   a_open_current: assert property (reg_rvalid_o && $past(stat_rd)
      |-> reg_rdata_o[2] == $past(current_on_o))
      else $error("enabled bit and current disagree");
   a_mode_write: assert property (reg_wr_i && reg_addr_i == dsc_pkg::ADDR_MODE
      |=> mode_o == $past(reg_wdata_i))
      else $error("mode not updated");
   a_fault_off: assert property (fault_i |=> !current_on_o)
      else $error("current on after fault");
   a_disv_off: assert property (cmd_wr && !reg_wdata_i[7] && !reg_wdata_i[1]
      |=> !current_on_o)
      else $error("current on after disable voltage");
   a_start_cause: assert property (motion_start_o
      |-> $past(start_cmd))
      else $error("motion start without command");
endmodule
bind dsc_top dsc_checker u_dsc_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .fault_i(fault_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .reg_err_o(reg_err_o),
   .current_on_o(current_on_o), .motion_start_o(motion_start_o),
   .mode_o(mode_o));
`default_nettype wire

// ===== tb/dsc_master_model.sv
// Register bus master model standing in for the remote controller
`timescale 1ns/1ps
`default_nettype none
module dsc_master_model (
   input wire logic core_clk_i,
   input wire logic [15:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   input wire logic reg_err_i,
   output logic [15:0] reg_addr_o,
   output logic [15:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   // Bus idles with both strobes low
   initial
   begin
      reg_addr_o = 16'h0000;
      reg_wdata_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // One word write; data inverted once no longer qualified
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
      #1;
   endtask
   // One word read; answer taken in the cycle it stands
   task automatic rd(input logic [15:0] a, output logic [15:0] d,
      output logic v, output logic e);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      #1;
      d = reg_rdata_i;
      v = reg_rvalid_i;
      e = reg_err_i;
   endtask
endmodule
`default_nettype wire

// ===== tb/dsc_top_bench.sv
// Self-checking bench for the drive state control block
`timescale 1ns/1ps
`default_nettype none
module dsc_top_bench;
   localparam int QUAL = 16;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hv_present_i = 1'b0;
   logic fault_i = 1'b0;
   logic motion_done_i = 1'b0;
   logic [15:0] addr, wdata, rdata, mode, rd_v;
   logic wr, rd, rvalid, err, cur, mstart, mrel, rd_ok, rd_e;
   logic [31:0] tpos;
   int num_errors = 0;
   int n_tests = 0;
   // Free running 50 MHz clock
   always #10 core_clk_i = ~core_clk_i;
   dsc_top #(.HV_QUAL_CYC(QUAL)) u_dsc_top (.core_clk_i(core_clk_i),
      .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .hv_present_i(hv_present_i), .fault_i(fault_i),
      .motion_done_i(motion_done_i), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .reg_err_o(err), .current_on_o(cur),
      .motion_start_o(mstart),
      .motion_rel_o(mrel), .mode_o(mode), .target_pos_o(tpos));
   dsc_master_model u_dsc_master_model (.core_clk_i(core_clk_i),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_err_i(err),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Command write and masked status read
   task automatic cmd(input logic [15:0] d);
      u_dsc_master_model.wr(dsc_pkg::ADDR_CMD, d);
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] x);
      u_dsc_master_model.rd(dsc_pkg::ADDR_STAT, rd_v, rd_ok, rd_e);
      chk({rd_ok, rd_e}, 2'b10);
      chk(rd_v & m, x);
   endtask
   // Supply gated walk up to operation enabled
   task automatic t_power;
      st(16'hFFFF, 16'h0260);
      chk(mode, 16'h0001);
      cmd(16'h0006);
      st(16'hFFFF, 16'h0221);
      cmd(16'h0007);
      st(16'hFFFF, 16'h0221);
      @(posedge core_clk_i) hv_present_i <= 1'b1;
      cmd(16'h0007);
      st(16'hFFFF, 16'h0231);
      repeat (QUAL + 4) @(posedge core_clk_i);
      cmd(16'h0007);
      st(16'hFFFF, 16'h0233);
      chk(cur, 1'b0);
      cmd(16'h000F);
      st(16'hFFFF, 16'h0637);
      chk(cur, 1'b1);
      $display("end power");
   endtask
   // Absolute and relative starts per mode
   task automatic t_motion;
      repeat (10) @(posedge core_clk_i);
      cmd(16'h001F);
      chk({mstart, mrel}, 2'b10);
      st(16'hFFFF, 16'h1237);
      @(posedge core_clk_i) motion_done_i <= 1'b1;
      @(posedge core_clk_i) motion_done_i <= 1'b0;
      cmd(16'h000F);
      cmd(16'h005F);
      chk({mstart, mrel}, 2'b11);
      u_dsc_master_model.wr(dsc_pkg::ADDR_MODE, 16'h0003);
      cmd(16'h000F);
      cmd(16'h005F);
      chk({mstart, mrel}, 2'b10);
      $display("end motion");
   endtask
   // Quick stop and return, then odd commands
   task automatic t_states;
      cmd(16'h000B);
      st(16'h006F, 16'h0007);
      cmd(16'h000F);
      st(16'h006F, 16'h0027);
      chk(cur, 1'b1);
      cmd(16'h0007);
      st(16'h006F, 16'h0023);
      chk(cur, 1'b0);
      cmd(16'h0000);
      cmd(16'h0007);
      cmd(16'h000F);
      st(16'h006F, 16'h0060);
      cmd(16'h0006);
      cmd(16'h000F);
      st(16'h006F, 16'h0027);
      $display("end states");
   endtask
   // Fault entry and fault reset edge
   task automatic t_fault;
      @(posedge core_clk_i) fault_i <= 1'b1;
      @(posedge core_clk_i) fault_i <= 1'b0;
      st(16'h004F, 16'h0008);
      chk(cur, 1'b0);
      cmd(16'h0080);
      st(16'h006F, 16'h0060);
      $display("end fault");
   endtask
   // Read-only status, unmapped access, mode and split target
   task automatic t_regs;
      u_dsc_master_model.wr(dsc_pkg::ADDR_STAT, 16'hFFFF);
      st(16'hFFFF, 16'h0270);
      u_dsc_master_model.rd(16'h0100, rd_v, rd_ok, rd_e);
      chk({rd_e, rd_v}, 17'h1_0000);
      u_dsc_master_model.wr(dsc_pkg::ADDR_MODE, dsc_pkg::MODE_PVEL);
      u_dsc_master_model.rd(dsc_pkg::ADDR_MODE, rd_v, rd_ok, rd_e);
      chk(rd_v, 16'h0003);
      u_dsc_master_model.wr(dsc_pkg::ADDR_MODE, 16'h0006);
      u_dsc_master_model.rd(dsc_pkg::ADDR_MODE, rd_v, rd_ok, rd_e);
      chk(rd_v, 16'h0006);
      u_dsc_master_model.wr(dsc_pkg::ADDR_TPOS_HI, 16'h1234);
      chk(tpos, 32'h0000_0000);
      u_dsc_master_model.wr(dsc_pkg::ADDR_TPOS_LO, 16'h5678);
      chk(tpos, 32'h1234_5678);
      $display("end regs");
   endtask
   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence after ten reset cycles
   initial
   begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_power();
      t_motion();
      t_states();
      t_fault();
      t_regs();
      finish_test();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #100000;
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
